/* inc/status_cond_pkg.sv */
// Shared constants, types and register map for status packing and conditional logic
package status_cond_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_REPORTS = 3;
    localparam int NUM_SLOTS   = 8;
    localparam int NUM_COND    = 10;
    localparam int NUM_INPUTS  = 4;
    localparam int NUM_DI      = 12;
    localparam int NUM_RELAY   = 8;
    localparam int NUM_RXMSG   = 10;
    localparam int NUM_TXMSG   = 12;
    localparam int NUM_FAULT   = 30;
    localparam int NUM_RXVAL   = 10;
    localparam int VAL_W       = 16;
    localparam int NUM_SLOT_CFG = NUM_REPORTS * NUM_SLOTS;

    // ==========================================================
    // Encodings
    typedef enum logic [2:0] {
        SRC_NONE, SRC_DIG_IN, SRC_RELAY, SRC_RX_MSG,
        SRC_TX_MSG, SRC_FAULT, SRC_RX_VAL, SRC_COND
    } source_e;

    typedef enum logic [2:0] {
        OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_OR, OP_AND
    } cond_op_e;

    typedef enum logic [1:0] {
        JOIN_OR, JOIN_AND, JOIN_XOR, JOIN_BAD
    } join_op_e;

    typedef struct packed {
        source_e     sel;
        logic [4:0]  idx;
        logic [3:0]  pos;
    } slot_cfg_s;

    typedef struct packed {
        source_e     sel;
        logic [4:0]  idx;
    } input_cfg_s;

    typedef struct packed {
        input_cfg_s [NUM_INPUTS-1:0] inp;
        cond_op_e                    op1;
        cond_op_e                    op2;
        join_op_e                    op3;
    } cond_cfg_s;

    // ==========================================================
    // Register map (byte addresses, decoded on haddr[11:0])
    localparam logic [11:0] SLOT_BASE    = 12'h000;
    localparam logic [11:0] SLOT_END     = SLOT_BASE + 12'(NUM_SLOT_CFG * 4);
    localparam logic [11:0] COND_BASE    = 12'h100;
    localparam int          COND_STRIDE  = 8;
    localparam logic [11:0] COND_END     = COND_BASE + 12'(NUM_COND * COND_STRIDE);
    localparam logic [11:0] STATUS_ADDR  = 12'h200;
    localparam logic [11:0] RESULT_ADDR  = 12'h204;

    // ==========================================================
    // Field positions
    localparam int SLOT_SEL_LSB = 0;
    localparam int SLOT_IDX_LSB = 4;
    localparam int SLOT_POS_LSB = 16;
    localparam int INP_STRIDE   = 8;
    localparam int INP_SEL_LSB  = 0;
    localparam int INP_IDX_LSB  = 3;
    localparam int OP1_LSB      = 0;
    localparam int OP2_LSB      = 4;
    localparam int OP3_LSB      = 8;

    // ==========================================================
    // Reset values
    localparam cond_op_e DEF_OP12 = OP_AND;
    localparam join_op_e DEF_OP3  = JOIN_OR;

    // Reports filled in order: inputs first, then relays, rest empty
    function automatic slot_cfg_s default_slot(int n);
        slot_cfg_s s;
        s.pos = 4'(n % NUM_SLOTS + 1);
        if (n < NUM_DI)
        begin
            s.sel = SRC_DIG_IN;
            s.idx = 5'(n + 1);
        end
        else if (n < NUM_DI + NUM_RELAY)
        begin
            s.sel = SRC_RELAY;
            s.idx = 5'(n - NUM_DI + 1);
        end
        else
        begin
            s.sel = SRC_NONE;
            s.idx = 5'h00;
            s.pos = 4'h0;
        end
        return s;
    endfunction

endpackage

/* src/source_select.sv */
// Source multiplexer for one status slot or conditional input
`timescale 1ns/100ps

module source_select
    import status_cond_pkg::*;
(
    input  wire source_e                       sel_i,
    input  wire logic [4:0]                    idx_i,
    input  wire logic [NUM_DI-1:0]             dig_in_i,
    input  wire logic [NUM_RELAY-1:0]          relay_i,
    input  wire logic [NUM_RXMSG-1:0]          rx_msg_i,
    input  wire logic [NUM_TXMSG-1:0]          tx_msg_i,
    input  wire logic [NUM_FAULT-1:0]          fault_i,
    input  wire logic [NUM_RXVAL-1:0][VAL_W-1:0] rx_val_i,
    input  wire logic [NUM_COND-1:0]           cond_i,
    output logic [VAL_W-1:0]                   value_o
);

    // ==========================================================
    // Index range check
    function automatic logic in_range(logic [4:0] idx, int n);
        return (idx != 5'h00) && (int'(idx) <= n);
    endfunction

    // Logical sources read as 0 or 1; out of range reads as zero
    function automatic logic [VAL_W-1:0] bit_at(logic [31:0] v, logic [4:0] idx, int n);
        logic [VAL_W-1:0] r;
        r = '0;
        if (in_range(idx, n))
            r[0] = v[5'(idx - 5'h01)];
        return r;
    endfunction

    // ==========================================================
    // Selection
    always_comb
    begin
        value_o = '0;
        case (sel_i)
            SRC_NONE:   value_o = '0;
            SRC_DIG_IN: value_o = bit_at(32'(dig_in_i), idx_i, NUM_DI);
            SRC_RELAY:  value_o = bit_at(32'(relay_i), idx_i, NUM_RELAY);
            SRC_RX_MSG: value_o = bit_at(32'(rx_msg_i), idx_i, NUM_RXMSG);
            SRC_TX_MSG: value_o = bit_at(32'(tx_msg_i), idx_i, NUM_TXMSG);
            SRC_FAULT:  value_o = bit_at(32'(fault_i), idx_i, NUM_FAULT);
            SRC_RX_VAL:
            begin
                if (in_range(idx_i, NUM_RXVAL))
                    value_o = rx_val_i[5'(idx_i - 5'h01)];
            end
            SRC_COND:   value_o = bit_at(32'(cond_i), idx_i, NUM_COND);
            default:    value_o = '0;
        endcase
    end

endmodule

/* src/status_pack_condition_logic.sv */
// Status-report byte packing and conditional blocks behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps

module status_pack_condition_logic
    import status_cond_pkg::*;
(
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           hsel_i,
    input  wire logic [31:0]                    haddr_i,
    input  wire logic [1:0]                     htrans_i,
    input  wire logic                           hwrite_i,
    input  wire logic [2:0]                     hsize_i,
    input  wire logic [31:0]                    hwdata_i,
    input  wire logic                           hready_i,
    output logic [31:0]                         hrdata_o,
    output logic                                hreadyout_o,
    output logic                                hresp_o,
    input  wire logic [NUM_DI-1:0]              dig_in_i,
    input  wire logic [NUM_RELAY-1:0]           relay_i,
    input  wire logic [NUM_RXMSG-1:0]           rx_msg_i,
    input  wire logic [NUM_TXMSG-1:0]           tx_msg_i,
    input  wire logic [NUM_FAULT-1:0]           fault_i,
    input  wire logic [NUM_RXVAL-1:0][VAL_W-1:0] rx_val_i,
    output logic [NUM_REPORTS-1:0][7:0]         status_report_byte_o,
    output logic [NUM_COND-1:0]                 cond_result_o
);

    // ==========================================================
    // State
    typedef struct packed {
        slot_cfg_s [NUM_SLOT_CFG-1:0]       slot;
        cond_cfg_s [NUM_COND-1:0]           cond;
        logic [NUM_REPORTS-1:0][7:0]        status;
        logic [NUM_COND-1:0]                result;
        logic                               wr_pend;
        logic [11:0]                        wr_addr;
        logic [31:0]                        rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [VAL_W-1:0] slot_val [NUM_SLOT_CFG];
    logic [VAL_W-1:0] inp_val  [NUM_COND][NUM_INPUTS];

    // ==========================================================
    // Reset image
    function automatic state_s reset_state();
        state_s s;
        s = '0;
        for (int n = 0; n < NUM_SLOT_CFG; n++)
            s.slot[n] = default_slot(n);
        for (int c = 0; c < NUM_COND; c++)
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
            begin
                s.cond[c].inp[k].sel = SRC_DIG_IN;
                s.cond[c].inp[k].idx = 5'(k + 1);
            end
            s.cond[c].op1 = DEF_OP12;
            s.cond[c].op2 = DEF_OP12;
            s.cond[c].op3 = DEF_OP3;
        end
        return s;
    endfunction

    // ==========================================================
    // Register decode, shared by the write and read paths
    function automatic logic is_slot(logic [11:0] a);
        return (a[1:0] == 2'b00) && (a >= SLOT_BASE) && (a < SLOT_END);
    endfunction

    function automatic logic is_cond(logic [11:0] a);
        return (a[1:0] == 2'b00) && (a >= COND_BASE) && (a < COND_END);
    endfunction

    function automatic state_s write_word(state_s s, logic [11:0] a, logic [31:0] d);
        state_s      t;
        logic [11:0] off;
        logic [4:0]  si;
        logic [3:0]  ci;
        t   = s;
        off = a - SLOT_BASE;
        si  = off[6:2];
        if (is_slot(a))
        begin
            t.slot[si].sel = source_e'(d[SLOT_SEL_LSB +: 3]);
            t.slot[si].idx = d[SLOT_IDX_LSB +: 5];
            t.slot[si].pos = d[SLOT_POS_LSB +: 4];
        end
        off = a - COND_BASE;
        ci  = off[6:3];
        if (is_cond(a) && !off[2])
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
            begin
                t.cond[ci].inp[k].sel = source_e'(d[k*INP_STRIDE+INP_SEL_LSB +: 3]);
                t.cond[ci].inp[k].idx = d[k*INP_STRIDE+INP_IDX_LSB +: 5];
            end
        end
        else if (is_cond(a))
        begin
            t.cond[ci].op1 = cond_op_e'(d[OP1_LSB +: 3]);
            t.cond[ci].op2 = cond_op_e'(d[OP2_LSB +: 3]);
            t.cond[ci].op3 = join_op_e'(d[OP3_LSB +: 2]);
        end
        return t;
    endfunction

    function automatic logic [31:0] read_word(state_s s, logic [11:0] a);
        logic [31:0] r;
        logic [11:0] off;
        logic [4:0]  si;
        logic [3:0]  ci;
        r   = 32'h0000_0000;
        off = a - SLOT_BASE;
        si  = off[6:2];
        if (is_slot(a))
        begin
            r[SLOT_SEL_LSB +: 3] = s.slot[si].sel;
            r[SLOT_IDX_LSB +: 5] = s.slot[si].idx;
            r[SLOT_POS_LSB +: 4] = s.slot[si].pos;
        end
        off = a - COND_BASE;
        ci  = off[6:3];
        if (is_cond(a) && !off[2])
        begin
            for (int k = 0; k < NUM_INPUTS; k++)
            begin
                r[k*INP_STRIDE+INP_SEL_LSB +: 3] = s.cond[ci].inp[k].sel;
                r[k*INP_STRIDE+INP_IDX_LSB +: 5] = s.cond[ci].inp[k].idx;
            end
        end
        else if (is_cond(a))
        begin
            r[OP1_LSB +: 3] = s.cond[ci].op1;
            r[OP2_LSB +: 3] = s.cond[ci].op2;
            r[OP3_LSB +: 2] = s.cond[ci].op3;
        end
        if (a == STATUS_ADDR)
            r = 32'(s.status);
        if (a == RESULT_ADDR)
            r = 32'(s.result);
        return r;
    endfunction

    // ==========================================================
    // Operators
    function automatic logic compare(cond_op_e op, logic [VAL_W-1:0] a, logic [VAL_W-1:0] b);
        logic t;
        case (op)
            OP_EQ:   t = (a == b);
            OP_NE:   t = (a != b);
            OP_GT:   t = (a > b);
            OP_GE:   t = (a >= b);
            OP_LT:   t = (a < b);
            OP_LE:   t = (a <= b);
            OP_OR:   t = (a != '0) || (b != '0);
            OP_AND:  t = (a != '0) && (b != '0);
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Code 3 is not a logical operator, so it yields false
    function automatic logic join_conds(join_op_e op, logic c1, logic c2);
        logic t;
        case (op)
            JOIN_OR:  t = c1 | c2;
            JOIN_AND: t = c1 & c2;
            JOIN_XOR: t = c1 ^ c2;
            default:  t = 1'b0;
        endcase
        return t;
    endfunction

    // ==========================================================
    // Source selection
    // Block results feed back from their registers, so chains of blocks
    // settle one cycle per stage instead of forming combinational loops.
    for (genvar g = 0; g < NUM_SLOT_CFG; g++)
    begin : g_slot
        source_select u_slot (
            .sel_i    (state_reg.slot[g].sel),
            .idx_i    (state_reg.slot[g].idx),
            .dig_in_i (dig_in_i),
            .relay_i  (relay_i),
            .rx_msg_i (rx_msg_i),
            .tx_msg_i (tx_msg_i),
            .fault_i  (fault_i),
            .rx_val_i (rx_val_i),
            .cond_i   (state_reg.result),
            .value_o  (slot_val[g])
        );
    end

    for (genvar c = 0; c < NUM_COND; c++)
    begin : g_cond
        for (genvar k = 0; k < NUM_INPUTS; k++)
        begin : g_inp
            source_select u_inp (
                .sel_i    (state_reg.cond[c].inp[k].sel),
                .idx_i    (state_reg.cond[c].inp[k].idx),
                .dig_in_i (dig_in_i),
                .relay_i  (relay_i),
                .rx_msg_i (rx_msg_i),
                .tx_msg_i (tx_msg_i),
                .fault_i  (fault_i),
                .rx_val_i (rx_val_i),
                .cond_i   (state_reg.result),
                .value_o  (inp_val[c][k])
            );
        end
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [3:0] pos;
        logic       c1;
        logic       c2;
        pos = 4'h0;
        c1  = 1'b0;
        c2  = 1'b0;
        state_next = state_reg;

        // Bus: write data lands in the cycle after its address phase
        if (state_reg.wr_pend)
            state_next = write_word(state_next, state_reg.wr_addr, hwdata_i);
        state_next.wr_pend = hsel_i && hready_i && htrans_i[1] && hwrite_i;
        state_next.wr_addr = haddr_i[11:0];
        // Reads see a write still in its data phase
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
            state_next.rdata = read_word(state_next, haddr_i[11:0]);

        // Status bytes; slots aimed at one position are ORed together
        state_next.status = '0;
        for (int i = 0; i < NUM_SLOT_CFG; i++)
        begin
            pos = state_reg.slot[i].pos;
            if (state_reg.slot[i].sel != SRC_NONE && pos >= 4'h1 && pos <= 4'h8)
                state_next.status[i / NUM_SLOTS][3'(pos - 4'h1)] |=
                    (slot_val[i] != '0);
        end

        // Conditional blocks
        for (int c = 0; c < NUM_COND; c++)
        begin
            c1 = compare(state_reg.cond[c].op1, inp_val[c][0], inp_val[c][1]);
            c2 = compare(state_reg.cond[c].op2, inp_val[c][2], inp_val[c][3]);
            state_next.result[c] = join_conds(state_reg.cond[c].op3, c1, c2);
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_reg <= reset_state();
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // Outputs
    assign hrdata_o             = state_reg.rdata;
    assign hreadyout_o          = 1'b1;
    assign hresp_o              = 1'b0;
    assign status_report_byte_o = state_reg.status;
    assign cond_result_o        = state_reg.result;

endmodule

/* verification/status_pack_condition_logic_assertions.sv */
// Port checks for status packing and conditional blocks
`timescale 1ns/100ps

module status_pack_assertions
    import status_cond_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic                   hready_i,
    input  wire logic [31:0]            hrdata_o,
    input  wire logic                   hreadyout_o,
    input  wire logic                   hresp_o,
    input  wire logic [NUM_DI-1:0]      dig_in_i,
    input  wire logic [NUM_RELAY-1:0]   relay_i,
    input  wire logic [NUM_REPORTS-1:0][7:0] status_report_byte_o,
    input  wire logic [NUM_COND-1:0]    cond_result_o
);
    // ==========================================================
    // Helpers: default config holds until the first write
    logic live_reg;
    logic dirty_reg;
    logic rd_taken;
    logic unmapped;
    logic dflt_cond;
    assign rd_taken  = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    assign unmapped  = (haddr_i[11:0] >= 12'h208)
                     || (haddr_i[11:0] >= SLOT_END && haddr_i[11:0] < COND_BASE);
    assign dflt_cond = (dig_in_i[0] & dig_in_i[1]) | (dig_in_i[2] & dig_in_i[3]);

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            live_reg  <= 1'b0;
            dirty_reg <= 1'b0;
        end
        else
        begin
            live_reg <= 1'b1;
            if (hsel_i && hready_i && htrans_i[1] && hwrite_i)
            begin
                dirty_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================
    // Sequences and properties
    sequence s_rd_take;
        rd_taken;
    endsequence
    sequence s_unmapped_rd;
        s_rd_take ##0 unmapped;
    endsequence
    sequence s_default_cfg;
        live_reg && !dirty_reg;
    endsequence

    property p_zero_wait;
        hreadyout_o == 1'b1;
    endproperty
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    property p_rep_inputs;
        s_default_cfg |-> status_report_byte_o[0] == $past(dig_in_i[7:0]);
    endproperty
    property p_rep_mixed;
        s_default_cfg |-> status_report_byte_o[1] == {$past(relay_i[3:0]), $past(dig_in_i[11:8])};
    endproperty
    property p_rep_tail;
        s_default_cfg |-> status_report_byte_o[2] == {4'h0, $past(relay_i[7:4])};
    endproperty
    property p_cond_default;
        s_default_cfg |-> cond_result_o == {NUM_COND{$past(dflt_cond)}};
    endproperty
    property p_unmapped_zero;
        s_unmapped_rd |=> hrdata_o == 32'h0;
    endproperty
    property p_rd_hold;
        !rd_taken |=> $stable(hrdata_o);
    endproperty

    a_zero_wait: assert property (p_zero_wait) else $error("hreadyout low");
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_rep_inputs: assert property (p_rep_inputs) else $error("report 1 wrong");
    a_rep_mixed: assert property (p_rep_mixed) else $error("report 2 wrong");
    a_rep_tail: assert property (p_rep_tail) else $error("report 3 wrong");
    a_cond_default: assert property (p_cond_default) else $error("block wrong");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
    a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
endmodule

bind status_pack_condition_logic status_pack_assertions i_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dig_in_i(dig_in_i), .relay_i(relay_i),
    .status_report_byte_o(status_report_byte_o), .cond_result_o(cond_result_o));

/* verification/tx_mapper_model.sv */
// Transmit mapper stand-in that consumes status bytes and block results
`timescale 1ns/100ps

module tx_mapper_model
    import status_cond_pkg::*;
(
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic [NUM_REPORTS-1:0][7:0] status_report_byte_i,
    input  wire logic [NUM_COND-1:0]         cond_result_i,
    output logic [31:0]                      tx_field_o
);
    // Full byte per report, a narrower field would drop bits
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_field_o <= 32'h0;
        else
            tx_field_o <= {cond_result_i[7:0], status_report_byte_i};
    end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for status packing and conditional blocks
`timescale 1ns/100ps

module tb_top
    import status_cond_pkg::*;
;
    logic                        clk, rst_n, hsel, hwrite, hrdy, hresp;
    logic [31:0]                 haddr, hwdata, hrdata;
    logic [1:0]                  htrans;
    logic [NUM_DI-1:0]           di;
    logic [NUM_RELAY-1:0]        rl;
    logic [NUM_RXMSG-1:0]        rxm;
    logic [NUM_TXMSG-1:0]        txm;
    logic [NUM_FAULT-1:0]        flt;
    logic [NUM_RXVAL-1:0][15:0]  rxv;
    logic [NUM_REPORTS-1:0][7:0] srb;
    logic [NUM_COND-1:0]         cres;
    logic [65:0]                 note_q[$];
    logic [65:0]                 note;
    logic [31:0]                 seed, w;
    logic                        f;
    int                          cyc, failures, n_checks;

    status_pack_condition_logic i_dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .dig_in_i(di), .relay_i(rl), .rx_msg_i(rxm), .tx_msg_i(txm), .fault_i(flt),
        .rx_val_i(rxv), .status_report_byte_o(srb), .cond_result_o(cres));
    tx_mapper_model i_tx (.core_clk_i(clk), .rst_n_i(rst_n), .status_report_byte_i(srb),
        .cond_result_i(cres), .tx_field_o());

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic cmp(input logic [2:0] o, input logic [15:0] a, b);
        case (o)
            3'h0: return a == b;
            3'h1: return a != b;
            3'h2: return a > b;
            3'h3: return a >= b;
            3'h4: return a < b;
            3'h5: return a <= b;
            3'h6: return (a != 0) || (b != 0);
            default: return (a != 0) && (b != 0);
        endcase
    endfunction
    task automatic chk(input string nm, input logic [33:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Single AHB transfer; a read compares against d
    task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= wr;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        chk("hresp", 34'h0, {33'h0, hresp});
        if (!wr) chk("hrdata", {2'h0, d}, {2'h0, hrdata});
    endtask
    // Drive inputs and note the outputs due one edge later
    task automatic apply(input logic [11:0] d, input logic [7:0] r,
                         input logic [15:0] v1, v2, input logic [33:0] e);
        @(posedge clk);
        di <= d; rl <= r; rxv[0] <= v1; rxv[1] <= v2;
        note_q.push_back({32'(cyc + 1), e});
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Clock, monitor, watchdog
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
    begin
        while (note_q.size() > 0 && note_q[0][65:34] == cyc)
        begin
            note = note_q.pop_front();
            chk("outputs", note[33:0], {srb, cres});
        end
        cyc++;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
        hwdata = 32'h0; di = '0; rl = '0; rxm = '0; txm = '0; flt = '0; rxv = '0;
        seed = 32'h0000A0C6; cyc = 0; failures = 0; n_checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30)
        begin
            seed = lfsr(seed);
            f = (seed[0] & seed[1]) | (seed[2] & seed[3]);
            apply(seed[11:0], seed[19:12], 16'h1, 16'h1, {4'h0, seed[19:12], seed[11:0],
                  {NUM_COND{f}}});
        end
        bus(12'h000, 1'b0, 32'h00010011);
        bus(12'h03C, 1'b0, 32'h00080042);
        bus(12'h05C, 1'b0, 32'h0);
        bus(12'h100, 1'b0, 32'h21191109);
        bus(12'h104, 1'b0, 32'h00000077);
        bus(12'h300, 1'b1, 32'hFFFFFFFF);
        bus(12'h300, 1'b0, 32'h0);
        bus(12'h080, 1'b0, 32'h0);
        rxm <= '1; txm <= '1; flt <= '1; rxv <= {NUM_RXVAL{16'h1}};
        for (int n = 1; n < 8; n++) bus(12'(4 * n), 1'b1, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            w = (32'(8 - c) << 16) | 32'h10 | 32'(c);
            bus(12'h000, 1'b1, w);
            bus(12'h000, 1'b0, w);
            apply(12'hFFF, 8'hFF, 16'h1, 16'h1, {8'h0F, 8'hFF,
                  (c == 0) ? 8'h00 : 8'(1 << (7 - c)), 10'h3FF});
        end
        bus(12'h000, 1'b1, 32'h0);
        // Inputs 1-3 from values, input 4 unselected and zero
        bus(12'h100, 1'b1, 32'h000E160E);
        for (int o = 0; o < 32; o++)
        begin
            bus(12'h104, 1'b1, 32'(o[2:0]) | 32'h20 | (32'(o[4:3]) << 8));
            repeat (4)
            begin
                seed = lfsr(seed);
                f = (o[4:3] == 0) ? (cmp(o[2:0], seed[1:0], seed[3:2]) | (seed[1:0] > 0)) :
                    (o[4:3] == 1) ? (cmp(o[2:0], seed[1:0], seed[3:2]) & (seed[1:0] > 0)) :
                    (o[4:3] == 2) ? (cmp(o[2:0], seed[1:0], seed[3:2]) ^ (seed[1:0] > 0)) :
                    1'b0;
                apply(12'hFFF, 8'hFF, 16'(seed[1:0]), 16'(seed[3:2]),
                      {8'h0F, 8'hFF, 8'h00, 9'h1FF, f});
            end
        end
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule
